// *** core/msru_pkg.sv ***
// Summary of operation
// - I/O barrier holds later accesses until earlier complete
// - Fetch barrier halts fetch until pipeline drains
// - Fetch barrier makes no bus activity
// - Address is base plus index, base zero-able
// - Load-reserve writes loaded word to destination
// - Load-reserve sets reservation, replacing old address
// - Misaligned load-reserve raises alignment exception
// - Reserved store-conditional clears reservation at issue, then writes
// - Unreserved store-conditional completes without memory write
// - Performed store-conditional sets success flag
// - Success decided by reservation at start
// - Misaligned store-conditional raises alignment exception
// - Full sync holds later instructions until completion
// - Full sync waits for globally performed accesses
// - Reservation cleared by listed events
// - Reservation covers 32-byte granule, any write breaks
// - Store-conditional ignores address mismatch with reservation
// - Failed store-conditional clears success flag
package msru_pkg;

   localparam int unsigned MSRU_ADDR_W         = 32;
   localparam int unsigned MSRU_DATA_W         = 32;
   localparam int unsigned MSRU_REG_W          = 5;
   localparam int unsigned MSRU_GRANULE_BYTES  = 32;
   localparam int unsigned MSRU_GRAN_LSB       = $clog2(MSRU_GRANULE_BYTES);
   localparam int unsigned MSRU_ALIGN_BITS     = 2;
   localparam logic        MSRU_RES_RESET      = 1'b0;

   typedef enum logic [2:0] {
      MSRU_OP_NONE   = 3'h0,
      MSRU_OP_IOORD  = 3'h1,
      MSRU_OP_FETCH  = 3'h2,
      MSRU_OP_SYNC   = 3'h3,
      MSRU_OP_LDRES  = 3'h4,
      MSRU_OP_STCOND = 3'h5
   } msru_op_type;

   typedef struct packed {
      msru_op_type             op;
      logic                    base_is_zero;
      logic [MSRU_ADDR_W-1:0]  base_src_reg;
      logic [MSRU_ADDR_W-1:0]  offset_reg;
      logic [MSRU_DATA_W-1:0]  store_source_reg;
      logic [MSRU_REG_W-1:0]   dest;
   } msru_issue_type;

   typedef struct packed {
      logic                    write;
      logic                    reserve;
      logic                    cond;
      logic [MSRU_ADDR_W-1:0]  computed_addr;
      logic [MSRU_DATA_W-1:0]  wdata;
   } msru_bus_req_type;

endpackage : msru_pkg

// *** core/msru_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module msru_unit
   import msru_pkg::*;
(
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Instruction issue
   input  wire logic              i_issue_valid,
   input  wire msru_issue_type    i_issue,
   output logic                   o_issue_ready,
   // Pipeline status
   input  wire logic              i_pipe_empty,
   input  wire logic              i_mem_idle,
   input  wire logic              i_mem_global_done,
   // Pipeline control
   output logic                   o_fetch_hold,
   output logic                   o_issue_hold,
   output logic                   o_mem_hold,
   // Exceptions that kill the reservation
   input  wire logic              i_sys_call,
   input  wire logic              i_exc_sync,
   input  wire logic              i_exc_async,
   // Load/store bus
   output logic                   o_ls_valid,
   output msru_bus_req_type       o_ls_req,
   input  wire logic              i_ls_ack,
   input  wire logic [MSRU_DATA_W-1:0] i_ls_rdata,
   input  wire logic              i_ls_cond_fail,
   // Writes by other agents
   input  wire logic              i_snoop_valid,
   input  wire logic [MSRU_ADDR_W-1:0] i_snoop_addr,
   // Results
   output logic                   o_done,
   output logic                   o_align_exc,
   output logic                   o_wb_valid,
   output logic [MSRU_REG_W-1:0]  o_wb_reg,
   output logic [MSRU_DATA_W-1:0] o_wb_data,
   output logic                   o_cond_field_zero_valid,
   output logic                   o_store_success_flag,
   // Reservation state
   output logic                   o_res_valid
);

   localparam int unsigned GRAN_W = MSRU_ADDR_W - MSRU_GRAN_LSB;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DRAIN,
      ST_BUS
   } msru_state_type;

   function automatic logic [GRAN_W-1:0] granule_of(input logic [MSRU_ADDR_W-1:0] a);
      granule_of = a[MSRU_ADDR_W-1:MSRU_GRAN_LSB];
   endfunction : granule_of

   // Control group
   msru_state_type          state;
   msru_state_type          next_state;
   msru_op_type             op;
   msru_op_type             next_op;
   logic [MSRU_REG_W-1:0]   dest;
   logic [MSRU_REG_W-1:0]   next_dest;
   logic                    next_issue_ready;
   logic                    next_fetch_hold;
   logic                    next_issue_hold;
   logic                    next_mem_hold;
   logic                    next_ls_valid;
   msru_bus_req_type        next_ls_req;
   logic                    next_done;
   logic                    next_align_exc;
   logic                    next_wb_valid;
   logic [MSRU_REG_W-1:0]   next_wb_reg;
   logic [MSRU_DATA_W-1:0]  next_wb_data;
   logic                    next_cfz_valid;
   logic                    next_success;
   // Reservation group
   logic                    res_valid;
   logic                    next_res_valid;
   logic [GRAN_W-1:0]       res_gran;
   logic [GRAN_W-1:0]       next_res_gran;

   logic [MSRU_ADDR_W-1:0]  computed_addr;
   logic                    take;
   logic                    misaligned;
   logic                    is_atomic;
   logic                    drain_done;
   logic                    res_set;
   logic                    res_clear;

   assign take          = i_issue_valid && o_issue_ready;
   assign computed_addr = (i_issue.base_is_zero ? '0 : i_issue.base_src_reg)
                          + i_issue.offset_reg;
   assign misaligned    = |computed_addr[MSRU_ALIGN_BITS-1:0];
   assign is_atomic     = (i_issue.op == MSRU_OP_LDRES) || (i_issue.op == MSRU_OP_STCOND);

   always_comb begin
      unique case (op)
         MSRU_OP_IOORD: drain_done = i_mem_idle;
         MSRU_OP_FETCH: drain_done = i_pipe_empty;
         default:       drain_done = i_pipe_empty && i_mem_global_done;
      endcase
   end

   always_comb begin
      next_state      = state;
      next_op         = op;
      next_dest       = dest;
      next_fetch_hold = o_fetch_hold;
      next_issue_hold = o_issue_hold;
      next_mem_hold   = o_mem_hold;
      next_ls_valid   = o_ls_valid;
      next_ls_req     = o_ls_req;
      next_done       = 1'b0;
      next_align_exc  = 1'b0;
      next_wb_valid   = 1'b0;
      next_wb_reg     = o_wb_reg;
      next_wb_data    = o_wb_data;
      next_cfz_valid  = 1'b0;
      next_success    = o_store_success_flag;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_op   = i_issue.op;
               next_dest = i_issue.dest;
               unique case (i_issue.op)
                  MSRU_OP_IOORD: begin
                     next_state    = ST_DRAIN;
                     next_mem_hold = 1'b1;
                  end
                  MSRU_OP_FETCH: begin
                     // Purely local: no bus request is made
                     next_state      = ST_DRAIN;
                     next_fetch_hold = 1'b1;
                  end
                  MSRU_OP_SYNC: begin
                     next_state      = ST_DRAIN;
                     next_issue_hold = 1'b1;
                     next_mem_hold   = 1'b1;
                  end
                  MSRU_OP_LDRES, MSRU_OP_STCOND: begin
                     if (misaligned) begin
                        next_align_exc = 1'b1;
                     end else if (i_issue.op == MSRU_OP_LDRES || res_valid) begin
                        // Reservation sampled here, at the start of execution
                        next_state                = ST_BUS;
                        next_ls_valid             = 1'b1;
                        next_ls_req.write         = (i_issue.op == MSRU_OP_STCOND);
                        next_ls_req.reserve       = (i_issue.op == MSRU_OP_LDRES);
                        next_ls_req.cond          = (i_issue.op == MSRU_OP_STCOND);
                        next_ls_req.computed_addr = computed_addr;
                        next_ls_req.wdata         = i_issue.store_source_reg;
                     end else begin
                        next_done      = 1'b1;
                        next_cfz_valid = 1'b1;
                        next_success   = 1'b0;
                     end
                  end
                  default: begin
                     next_op = MSRU_OP_NONE;
                  end
               endcase
            end
         end
         ST_DRAIN: begin
            if (drain_done) begin
               next_state      = ST_IDLE;
               next_fetch_hold = 1'b0;
               next_issue_hold = 1'b0;
               next_mem_hold   = 1'b0;
               next_done       = 1'b1;
            end
         end
         ST_BUS: begin
            if (i_ls_ack) begin
               next_state    = ST_IDLE;
               next_ls_valid = 1'b0;
               next_done     = 1'b1;
               if (op == MSRU_OP_LDRES) begin
                  next_wb_valid = 1'b1;
                  next_wb_reg   = dest;
                  next_wb_data  = i_ls_rdata;
               end else begin
                  // Bus interface may still refuse if the granule was lost
                  next_cfz_valid = 1'b1;
                  next_success   = !i_ls_cond_fail;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_issue_ready = (next_state == ST_IDLE);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state                   <= ST_IDLE;
         op                      <= MSRU_OP_NONE;
         dest                    <= '0;
         o_issue_ready           <= 1'b1;
         o_fetch_hold            <= 1'b0;
         o_issue_hold            <= 1'b0;
         o_mem_hold              <= 1'b0;
         o_ls_valid              <= 1'b0;
         o_ls_req                <= '0;
         o_done                  <= 1'b0;
         o_align_exc             <= 1'b0;
         o_wb_valid              <= 1'b0;
         o_wb_reg                <= '0;
         o_wb_data               <= '0;
         o_cond_field_zero_valid <= 1'b0;
         o_store_success_flag    <= 1'b0;
      end else begin
         state                   <= next_state;
         op                      <= next_op;
         dest                    <= next_dest;
         o_issue_ready           <= next_issue_ready;
         o_fetch_hold            <= next_fetch_hold;
         o_issue_hold            <= next_issue_hold;
         o_mem_hold              <= next_mem_hold;
         o_ls_valid              <= next_ls_valid;
         o_ls_req                <= next_ls_req;
         o_done                  <= next_done;
         o_align_exc             <= next_align_exc;
         o_wb_valid              <= next_wb_valid;
         o_wb_reg                <= next_wb_reg;
         o_wb_data               <= next_wb_data;
         o_cond_field_zero_valid <= next_cfz_valid;
         o_store_success_flag    <= next_success;
      end
   end

   // Reservation: set wins over a clear in the same cycle
   assign res_set   = (state == ST_BUS) && i_ls_ack && (op == MSRU_OP_LDRES);
   assign res_clear = (take && i_issue.op == MSRU_OP_STCOND)
                      || (take && is_atomic && misaligned)
                      || i_sys_call || i_exc_sync || i_exc_async
                      || (i_snoop_valid && res_valid
                          && granule_of(i_snoop_addr) == res_gran);

   always_comb begin
      next_res_valid = res_valid;
      next_res_gran  = res_gran;
      if (res_clear) begin
         next_res_valid = 1'b0;
      end
      if (res_set) begin
         next_res_valid = 1'b1;
         next_res_gran  = granule_of(o_ls_req.computed_addr);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         res_valid   <= MSRU_RES_RESET;
         res_gran    <= '0;
         o_res_valid <= MSRU_RES_RESET;
      end else begin
         res_valid   <= next_res_valid;
         res_gran    <= next_res_gran;
         o_res_valid <= next_res_valid;
      end
   end

endmodule : msru_unit
`default_nettype wire

// *** testbench/msru_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module msru_assertions
   import msru_pkg::*;
(
   // Watched ports, grouped to keep the checker short
   input wire logic                   i_sys_clk, i_rst, i_issue_valid, o_issue_ready,
   input wire msru_issue_type         i_issue,
   input wire logic                   i_pipe_empty, i_mem_idle, i_mem_global_done,
   input wire logic                   o_fetch_hold, o_issue_hold, o_mem_hold, o_ls_valid,
   input wire msru_bus_req_type       o_ls_req,
   input wire logic                   i_sys_call, i_exc_sync, i_exc_async, i_ls_ack,
   input wire logic                   i_ls_cond_fail, o_done, o_align_exc, o_wb_valid,
   input wire logic [MSRU_DATA_W-1:0] i_ls_rdata, o_wb_data,
   input wire logic                   o_cond_field_zero_valid, o_store_success_flag, o_res_valid
);
   logic                   tk;
   logic                   ok;
   logic [MSRU_ADDR_W-1:0] ca;
   assign tk = i_issue_valid && o_issue_ready;
   assign ca = (i_issue.base_is_zero ? '0 : i_issue.base_src_reg) + i_issue.offset_reg;
   assign ok = ca[1:0] == 2'h0;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   ldres_req_a:
      assert property (tk && i_issue.op == MSRU_OP_LDRES && ok |=> o_ls_valid
         && o_ls_req.reserve && o_ls_req.computed_addr == $past(ca)) else $error("bad reserve req");
   load_wb_a:
      assert property (o_ls_valid && i_ls_ack && o_ls_req.reserve |=> o_wb_valid && o_res_valid
         && o_wb_data == $past(i_ls_rdata)) else $error("bad load write-back");
   align_exc_a:
      assert property (tk && i_issue.op inside {MSRU_OP_LDRES, MSRU_OP_STCOND} && !ok
         |=> o_align_exc && !o_done && !o_ls_valid) else $error("missing alignment exception");
   cond_fail_a:
      assert property (tk && i_issue.op == MSRU_OP_STCOND && ok && !o_res_valid |=> !o_ls_valid
         && o_cond_field_zero_valid && !o_store_success_flag) else $error("bad failed store");
   cond_res_a:
      assert property (tk && i_issue.op == MSRU_OP_STCOND && ok && o_res_valid |=> o_ls_valid
         && o_ls_req.cond && o_ls_req.write && !o_res_valid
         && o_ls_req.wdata == $past(i_issue.store_source_reg)) else $error("bad cond store");
   cond_flag_a:
      assert property (o_ls_valid && i_ls_ack && o_ls_req.cond |=> o_cond_field_zero_valid
         && o_store_success_flag == !$past(i_ls_cond_fail)) else $error("bad success flag");
   io_order_a:
      assert property (o_mem_hold && !o_issue_hold |=> o_done == $past(i_mem_idle)
         && o_mem_hold == !$past(i_mem_idle) && !o_ls_valid) else $error("bad io barrier");
   fetch_wait_a:
      assert property (o_fetch_hold |=> !o_ls_valid && o_done == $past(i_pipe_empty)
         && o_fetch_hold == !$past(i_pipe_empty)) else $error("bad fetch barrier");
   sync_wait_a:
      assert property (o_issue_hold |=> o_issue_hold == !$past(i_pipe_empty && i_mem_global_done)
         && o_done == !o_issue_hold) else $error("bad full sync");
   res_clear_a:
      assert property ((i_sys_call || i_exc_sync || i_exc_async) && !i_ls_ack |=> !o_res_valid)
      else $error("reservation survived event");
endmodule : msru_assertions
bind msru_unit msru_assertions msru_assertions_inst (.i_sys_clk, .i_rst, .i_issue_valid,
   .o_issue_ready, .i_issue, .i_pipe_empty, .i_mem_idle, .i_mem_global_done, .o_fetch_hold,
   .o_issue_hold, .o_mem_hold, .o_ls_valid, .o_ls_req, .i_sys_call, .i_exc_sync, .i_exc_async,
   .i_ls_ack, .i_ls_cond_fail, .o_done, .o_align_exc, .o_wb_valid, .i_ls_rdata, .o_wb_data,
   .o_cond_field_zero_valid, .o_store_success_flag, .o_res_valid);
`default_nettype wire

// *** testbench/msru_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module msru_bus_model
   import msru_pkg::*;
(
   input wire logic                   i_sys_clk, i_rst, i_ls_valid, i_lose,
   input wire logic [3:0]             i_wait,
   input wire msru_bus_req_type       i_ls_req,
   output logic                       o_ack, o_cond_fail,
   output logic [MSRU_DATA_W-1:0]     o_rdata
);
   logic [MSRU_DATA_W-1:0] mem [16];
   logic [3:0]             cnt;
   initial for (int i = 0; i < 16; i++) mem[i] = 32'hc0de0000 + i;
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0; o_ack <= 1'b0; o_cond_fail <= 1'b0; o_rdata <= '0;
      end else begin
         o_ack <= 1'b0;
         o_cond_fail <= 1'b0;
         // Stale read data is scrambled so nothing relies on it
         o_rdata <= ~o_rdata;
         if (i_ls_valid && !o_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == i_wait) begin
               cnt <= '0;
               o_ack <= 1'b1;
               o_rdata <= mem[i_ls_req.computed_addr[5:2]];
               o_cond_fail <= i_ls_req.cond && i_lose;
               if (i_ls_req.write && !(i_ls_req.cond && i_lose))
                  mem[i_ls_req.computed_addr[5:2]] <= i_ls_req.wdata;
            end
         end
      end
   end
endmodule : msru_bus_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
   import msru_pkg::*;
   logic clk, rst, iv, pe, mi, mg, sc, es, ea, sv, lose, rdy, fh, ih, mh, lv, ack, cf;
   logic dn, ax, wbv, czv, flg, res;
   logic [4:0] wbr;
   logic [3:0] wt;
   logic [31:0] sa, wbd, rd;
   msru_issue_type iss;
   msru_bus_req_type req;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   msru_unit msru_unit_inst (.i_sys_clk(clk), .i_rst(rst), .i_issue_valid(iv), .i_issue(iss),
      .o_issue_ready(rdy), .i_pipe_empty(pe), .i_mem_idle(mi), .i_mem_global_done(mg),
      .o_fetch_hold(fh), .o_issue_hold(ih), .o_mem_hold(mh), .i_sys_call(sc), .i_exc_sync(es),
      .i_exc_async(ea), .o_ls_valid(lv), .o_ls_req(req), .i_ls_ack(ack), .i_ls_rdata(rd),
      .i_ls_cond_fail(cf), .i_snoop_valid(sv), .i_snoop_addr(sa), .o_done(dn),
      .o_align_exc(ax), .o_wb_valid(wbv), .o_wb_reg(wbr), .o_wb_data(wbd),
      .o_cond_field_zero_valid(czv), .o_store_success_flag(flg), .o_res_valid(res));
   msru_bus_model msru_bus_model_inst (.i_sys_clk(clk), .i_rst(rst), .i_ls_valid(lv),
      .i_lose(lose), .i_wait(wt), .i_ls_req(req), .o_ack(ack), .o_cond_fail(cf), .o_rdata(rd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic put(msru_op_type op, logic bz, logic [31:0] b, o, d, logic [3:0] w);
      @(posedge clk);
      iv <= 1'b1;
      iss <= '{op, bz, b, o, d, 5'h07};
      wt <= w;
      @(posedge clk);
      iv <= 1'b0;
      // One-cycle answers stand right after the take edge
      #1;
      for (int i = 0; i < 40 && !(dn || ax); i++) begin
         @(posedge clk);
         #1;
      end
   endtask : put
   task automatic t_load();
      put(MSRU_OP_LDRES, 1'b0, 32'h100, 32'h8, 32'h0, 4'h0);
      `CHK("load data", 32'hc0de0002, wbd)
      `CHK("load flags", 8'hc7, {wbv, res, 1'b0, wbr})
      put(MSRU_OP_LDRES, 1'b1, 32'hffff0000, 32'h10, 32'h0, 4'h3);
      `CHK("zero base", 32'hc0de0004, wbd)
      $display("test load done");
   endtask : t_load
   task automatic t_store();
      put(MSRU_OP_LDRES, 1'b0, 32'h100, 32'h0, 32'h0, 4'h0);
      put(MSRU_OP_STCOND, 1'b0, 32'h200, 32'hc, 32'h5a5a0001, 4'h2);
      `CHK("store ok", 3'h6, {czv, flg, res})
      put(MSRU_OP_STCOND, 1'b0, 32'h200, 32'hc, 32'h11, 4'h0);
      `CHK("store none", 3'h4, {czv, flg, lv})
      put(MSRU_OP_LDRES, 1'b0, 32'h20c, 32'h0, 32'h0, 4'h1);
      `CHK("memory", 32'h5a5a0001, wbd)
      lose <= 1'b1;
      put(MSRU_OP_STCOND, 1'b0, 32'h20c, 32'h0, 32'h22, 4'h0);
      `CHK("store lost", 3'h4, {czv, flg, res})
      lose <= 1'b0;
      $display("test store done");
   endtask : t_store
   task automatic t_align();
      put(MSRU_OP_LDRES, 1'b0, 32'h100, 32'h0, 32'h0, 4'h0);
      put(MSRU_OP_LDRES, 1'b0, 32'h100, 32'h2, 32'h0, 4'h0);
      `CHK("load align", 3'h4, {ax, dn, res})
      put(MSRU_OP_STCOND, 1'b0, 32'h100, 32'h1, 32'h0, 4'h0);
      `CHK("store align", 2'h2, {ax, dn})
      $display("test align done");
   endtask : t_align
   task automatic t_clear();
      for (int k = 0; k < 5; k++) begin
         put(MSRU_OP_LDRES, 1'b0, 32'h100, 32'h0, 32'h0, 4'h0);
         @(posedge clk);
         {sc, es, ea} <= 3'h4 >> k;
         sv <= k > 2;
         sa <= (k == 3) ? 32'h11c : 32'h120;
         @(posedge clk);
         {sc, es, ea, sv} <= 4'h0;
         @(posedge clk);
         #1;
         `CHK("reservation", k == 4, res)
      end
      $display("test clear done");
   endtask : t_clear
   task automatic t_barrier();
      msru_op_type ops [3] = '{MSRU_OP_IOORD, MSRU_OP_FETCH, MSRU_OP_SYNC};
      logic [2:0]  hx  [3] = '{3'h1, 3'h4, 3'h3};
      for (int k = 0; k < 3; k++) begin
         fork
            put(ops[k], 1'b0, 32'h0, 32'h0, 32'h0, 4'h0);
            begin
               repeat (5) @(posedge clk);
               #1;
               `CHK("holds", {hx[k], 2'h0}, {fh, ih, mh, dn, rdy})
               @(posedge clk);
               mg <= 1'b1;
               repeat (3) @(posedge clk);
               #1;
               `CHK("still held", {hx[k], 1'b0}, {fh, ih, mh, dn})
               @(posedge clk);
               {pe, mi} <= 2'h3;
            end
         join
         `CHK("released", 5'h3, {fh, ih, mh, dn, rdy})
         @(posedge clk);
         {pe, mi, mg} <= 3'h0;
      end
      $display("test barrier done");
   endtask : t_barrier
   initial begin
      rst = 1'b1; iv = 1'b0; iss = '0; {pe, mi, mg, sc, es, ea, sv, lose} = '0;
      sa = '0; wt = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_load();
      t_store();
      t_align();
      t_clear();
      t_barrier();
      conclude();
   end
endmodule : testbench
`default_nettype wire
